// ---- hdl/tmcore_top.sv ----
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
module tmcore_top import tmcore_pkg::*; (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic EXT_CLK_PIN_I,
    output logic EXT_PIN_FORCE_IN_O,
    input wire logic [5:0] CH_PIN_I,
    output logic [5:0] CH_PIN_O,
    output logic [5:0] CH_PIN_OE_B_O,
    output logic OVF_IRQ_O,
    output logic [5:0] CH_IRQ_O
);
    // bus decode
    wire acc = PSEL_I & PENABLE_I;
    wire rd = acc & ~PREADY_O & ~PWRITE_I;
    wire wr = acc & PREADY_O & PWRITE_I;
    wire [7:0] a = PADDR_I;
    wire [7:0] wd = PWDATA_I[7:0];
    wire rd_stat = rd & (a == A_STAT);
    wire wr_stat = wr & (a == A_STAT);
    wire rd_cnth = rd & (a == A_CNTH);
    wire rd_cntl = rd & (a == A_CNTL);
    wire wr_modh = wr & (a == A_MODH);
    wire wr_modl = wr & (a == A_MODL);
    wire ch_sc_hit = (a >= A_CSC) && (a < A_CSC + 8'h18) && (a[1:0] == 2'h0);
    wire ch_vl_hit = (a >= A_CVAL) && (a < A_CVAL + 8'h18) && (a[1:0] == 2'h0);
    wire map_ok = (a <= A_MODL && a[1:0] == 2'h0) || ch_sc_hit || ch_vl_hit;
    wire [2:0] sc_idx = 3'((a - A_CSC) >> 2);
    wire [2:0] vl_idx = 3'((a - A_CVAL) >> 2);

    logic halt_q; // counter halted
    logic overflow_irq_enable_q; // overflow request enable
    logic tof_q; // overflow flag
    logic tof_arm_q; // flag read while set, clear allowed
    logic mod_lock_q; // modulo high written, low pending
    logic lat_v_q; // low byte held in buffer
    logic [2:0] ps_q; // prescale select
    logic [15:0] cnt_q; // counter
    logic [15:0] mod_q; // modulo
    logic [5:0] psc_q; // prescaler
    logic [7:0] lat_q; // low byte buffer
    logic [2:0] xs_q; // external clock sync chain
    logic [5:0] s1_q; // channel pin sync, first stage
    logic [5:0] s2_q; // channel pin sync, second stage
    logic [5:0] s3_q; // channel pin edge history
    logic ovf_ev_q; // overflow seen last cycle
    logic cchg_q; // counter advanced last cycle
    logic [7:0] ctl_q [NCH];
    logic [15:0] val_q [NCH];
    logic [5:0] chf_q;
    logic [2:0] act_odd_q;

    // external clock edge and prescaler tap
    wire ext_rise = xs_q[1] & ~xs_q[2];
    wire [5:0] pmask = 6'((7'h01 << ps_q) - 7'h01);
    wire psc_tap = &(psc_q | ~pmask);
    wire src_tick = (ps_q == PS_EXT) ? ext_rise : psc_tap;
    wire tick = src_tick & ~halt_q;
    wire ovf = tick & (cnt_q == mod_q);
    wire clr_cnt = wr_stat & wd[B_CLR];
    wire tof_clr = wr_stat & ~wd[B_TOF] & tof_arm_q & ~halt_q;
    wire tof_set = ovf & ~mod_lock_q;

    // synchronisers
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            xs_q <= 3'h0;
            s1_q <= 6'h00;
            s2_q <= 6'h00;
            s3_q <= 6'h00;
        end else begin
            xs_q <= {xs_q[1:0], EXT_CLK_PIN_I};
            s1_q <= CH_PIN_I;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // prescaler, zeroed by the clear bit
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            psc_q <= 6'h00;
        end else begin
            psc_q <= clr_cnt ? 6'h00 : psc_q + 6'h01;
        end
    end

    // counter, clear beats overflow beats tick
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            cnt_q <= 16'h0000;
        end else if (clr_cnt) begin
            cnt_q <= 16'h0000;
        end else if (ovf) begin
            cnt_q <= 16'h0000;
        end else if (tick) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // overflow and count events delayed for the channels
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            ovf_ev_q <= 1'b0;
            cchg_q <= 1'b0;
        end else begin
            ovf_ev_q <= ovf & ~clr_cnt;
            cchg_q <= tick & ~clr_cnt;
        end
    end

    // status and control register
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            halt_q <= 1'b1;
            overflow_irq_enable_q <= 1'b0;
            ps_q <= 3'h0;
        end else if (wr_stat) begin
            halt_q <= wd[B_HALT];
            overflow_irq_enable_q <= wd[B_OVERFLOW_IRQ_ENABLE];
            ps_q <= wd[2:0];
        end
    end

    // overflow flag, set wins over clear
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            tof_q <= 1'b0;
        end else begin
            tof_q <= tof_set | (tof_q & ~tof_clr);
        end
    end

    // clear arming: read while set, voided by new overflow or any status register write
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            tof_arm_q <= 1'b0;
        end else if (tof_set || wr_stat) begin
            tof_arm_q <= 1'b0;
        end else if (rd_stat && tof_q) begin
            tof_arm_q <= 1'b1;
        end
    end

    // modulo value and high-byte lock
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            mod_q <= MOD_RST;
            mod_lock_q <= 1'b0;
        end else begin
            if (wr_modh) begin
                mod_q[15:8] <= wd;
                mod_lock_q <= 1'b1;
            end
            if (wr_modl) begin
                mod_q[7:0] <= wd;
                mod_lock_q <= 1'b0;
            end
        end
    end

    // counter read latch, low byte held after a high read
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            lat_q <= 8'h00;
            lat_v_q <= 1'b0;
        end else if (clr_cnt || rd_cntl) begin
            lat_v_q <= 1'b0;
            lat_q <= 8'h00;
        end else if (rd_cnth && !lat_v_q) begin
            lat_v_q <= 1'b1;
            lat_q <= cnt_q[7:0];
        end
    end

    // channels
    genvar i;
    generate
        for (i = 0; i < NCH; i++) begin : g_ch
            localparam bit ODD = (i % 2) == 1;
            localparam int EV = i - (i % 2);
            logic arm_q; // flag read while set
            logic out_q; // pin level
            logic oe_b_q; // pin drive enable, low drives
            logic max_q; // full duty taken at overflow
            logic irq_q; // channel request
            wire dis = ODD && ctl_q[EV][B_MSB];
            wire msb = ctl_q[i][B_MSB];
            wire msa = ctl_q[i][B_MSA];
            wire [1:0] els = ctl_q[i][3:2];
            wire on = (els != 2'h0) & ~dis;
            wire capm = on & ~msb & ~msa;
            wire cmpm = on & (msb | msa);
            wire tov = ctl_q[i][B_TOV];
            wire [15:0] cv = (!ODD && msb && act_odd_q[i / 2]) ? val_q[i | 1] : val_q[i];
            wire edge_hit = (els[0] & s2_q[i] & ~s3_q[i]) | (els[1] & ~s2_q[i] & s3_q[i]);
            wire cap = capm & ~halt_q & edge_hit;
            wire cmp = cmpm & cchg_q & (cnt_q == cv);
            wire ev = cap | cmp;
            wire rdc = rd & ch_sc_hit & (sc_idx == 3'(i));
            wire wrc = wr & ch_sc_hit & (sc_idx == 3'(i));
            wire wrv = wr & ch_vl_hit & (vl_idx == 3'(i));
            wire clr = wrc & ~wd[B_CHF] & arm_q & ~halt_q;

            // flag, control and value
            always_ff @(posedge CLK_I) begin
                if (!RST_B_I) begin
                    chf_q[i] <= 1'b0;
                    arm_q <= 1'b0;
                    ctl_q[i] <= 8'h00;
                    val_q[i] <= 16'h0000;
                end else begin
                    chf_q[i] <= ev | (chf_q[i] & ~clr);
                    if (ev || wrc) begin
                        arm_q <= 1'b0;
                    end else if (rdc && chf_q[i]) begin
                        arm_q <= 1'b1;
                    end
                    if (wrc && !dis) begin
                        ctl_q[i] <= wd & (ODD ? CTL_MASK_ODD : CTL_MASK_EVEN);
                    end
                    if (cap) begin
                        val_q[i] <= cnt_q;
                    end else if (wrv) begin
                        val_q[i] <= PWDATA_I[15:0];
                    end
                end
            end

            // pin output
            always_ff @(posedge CLK_I) begin
                if (!RST_B_I) begin
                    out_q <= 1'b1;
                    oe_b_q <= 1'b1;
                    max_q <= 1'b0;
                    irq_q <= 1'b0;
                end else begin
                    irq_q <= chf_q[i] & ctl_q[i][B_CHIE];
                    oe_b_q <= ~cmpm;
                    if (ovf_ev_q) begin
                        max_q <= ctl_q[i][B_MAX];
                    end
                    if (els == 2'h0) begin
                        out_q <= ~msa;
                    end else if (cmpm && ovf_ev_q && tov) begin
                        out_q <= max_q ? ~els[0] : ~out_q;
                    end else if (cmp && !(max_q && tov)) begin
                        out_q <= (els == 2'h1) ? ~out_q : els[0];
                    end
                end
            end
            assign CH_PIN_O[i] = out_q;
            assign CH_PIN_OE_B_O[i] = oe_b_q;
            assign CH_IRQ_O[i] = irq_q;

            // buffered pair register select
            if (!ODD) begin : g_pair
                logic nxt_q;
                wire wr_odd = wr & ch_vl_hit & (vl_idx == 3'(i + 1));
                always_ff @(posedge CLK_I) begin
                    if (!RST_B_I) begin
                        nxt_q <= 1'b0;
                        act_odd_q[i / 2] <= 1'b0;
                    end else begin
                        if (wr_odd) begin
                            nxt_q <= 1'b1;
                        end else if (wrv) begin
                            nxt_q <= 1'b0;
                        end
                        if (!msb) begin
                            act_odd_q[i / 2] <= 1'b0;
                        end else if (ovf_ev_q) begin
                            act_odd_q[i / 2] <= nxt_q;
                        end
                    end
                end
            end
        end
    endgenerate

    // read data mux
    logic [7:0] rsel;
    always_comb begin
        rsel = 8'h00;
        if (a == A_STAT) begin
            rsel = {tof_q, overflow_irq_enable_q, halt_q, 1'b0, 1'b0, ps_q};
        end else if (a == A_CNTH) begin
            rsel = cnt_q[15:8];
        end else if (a == A_CNTL) begin
            rsel = lat_v_q ? lat_q : cnt_q[7:0];
        end else if (a == A_MODH) begin
            rsel = mod_q[15:8];
        end else if (a == A_MODL) begin
            rsel = mod_q[7:0];
        end else if (ch_sc_hit && !(sc_idx[0] && ctl_q[sc_idx - 3'h1][B_MSB])) begin
            rsel = {chf_q[sc_idx], ctl_q[sc_idx][6:0]};
        end
    end
    wire [31:0] rdata = ch_vl_hit ? {16'h0000, val_q[vl_idx]} : {24'h000000, rsel};

    // bus answer, one wait state
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h00000000;
        end else begin
            PREADY_O <= acc & ~PREADY_O;
            PSLVERR_O <= acc & ~PREADY_O & ~map_ok;
            PRDATA_O <= rd ? (map_ok ? rdata : 32'h00000000) : 32'h00000000;
        end
    end

    // overflow request, blocked while modulo low write pending; pin direction
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            OVF_IRQ_O <= 1'b0;
            EXT_PIN_FORCE_IN_O <= 1'b0;
        end else begin
            OVF_IRQ_O <= tof_q & overflow_irq_enable_q & ~mod_lock_q;
            EXT_PIN_FORCE_IN_O <= (ps_q == PS_EXT);
        end
    end
endmodule

// ---- hdl/tmcore_pkg.sv ----
package tmcore_pkg;
    localparam int NCH = 6;
    localparam logic [7:0] A_STAT = 8'h00;
    localparam logic [7:0] A_CNTH = 8'h04;
    localparam logic [7:0] A_CNTL = 8'h08;
    localparam logic [7:0] A_MODH = 8'h0C;
    localparam logic [7:0] A_MODL = 8'h10;
    localparam logic [7:0] A_CSC = 8'h14;
    localparam logic [7:0] A_CVAL = 8'h30;
    localparam int B_TOF = 7;
    localparam int B_OVERFLOW_IRQ_ENABLE = 6;
    localparam int B_HALT = 5;
    localparam int B_CLR = 4;
    localparam int B_CHF = 7;
    localparam int B_CHIE = 6;
    localparam int B_MSB = 5;
    localparam int B_MSA = 4;
    localparam int B_TOV = 1;
    localparam int B_MAX = 0;
    localparam logic [2:0] PS_EXT = 3'h7;
    localparam logic [15:0] MOD_RST = 16'hFFFF;
    localparam logic [7:0] CTL_MASK_EVEN = 8'h7F;
    localparam logic [7:0] CTL_MASK_ODD = 8'h5F;
endpackage

// ---- test/tmcore_checker.sv ----
`timescale 1ns/10ps
module tmcore_checker import tmcore_pkg::*; (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic EXT_PIN_FORCE_IN_O,
    input wire logic OVF_IRQ_O,
    input wire logic [5:0] CH_IRQ_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    // completed writes by target
    wire logic wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    wire logic wr_stat = wr && PADDR_I == A_STAT;
    wire logic wr_mod = wr && PADDR_I == A_MODH;
    wire logic wr_ch = wr && PADDR_I >= A_CSC && PADDR_I < A_CVAL;
    property p_rdy_pulse; PREADY_O |=> !PREADY_O; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held too long");
    property p_rdata_idle; !PREADY_O |-> PRDATA_O == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
    property p_slverr; PREADY_O && PADDR_I == 8'hFC |-> PSLVERR_O; endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
    property p_err_ready; PSLVERR_O |-> PREADY_O; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_clr_rd0; PREADY_O && !PWRITE_I && PADDR_I == A_STAT |-> !PRDATA_O[B_CLR]; endproperty
    a_clr_rd0: assert property (p_clr_rd0) else $error("clear bit read as one");
    property p_force_in; $changed(EXT_PIN_FORCE_IN_O) |-> $past(wr_stat) || $past(wr_stat, 2); endproperty
    a_force_in: assert property (p_force_in) else $error("pin direction changed unprompted");
    property p_ovf_fall; $fell(OVF_IRQ_O) |-> $past(wr_stat || wr_mod) || $past(wr_stat || wr_mod, 2); endproperty
    a_ovf_fall: assert property (p_ovf_fall) else $error("overflow request dropped unprompted");
    property p_ch_fall; ($past(CH_IRQ_O) & ~CH_IRQ_O) != 6'h00 |-> $past(wr_ch) || $past(wr_ch, 2); endproperty
    a_ch_fall: assert property (p_ch_fall) else $error("channel request dropped unprompted");
    property p_irq_rst; $rose(RST_B_I) |-> !OVF_IRQ_O && CH_IRQ_O == 6'h00; endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("request active after reset");
endmodule

// ---- test/tmcore_pin_model.sv ----
`timescale 1ns/10ps
module tmcore_pin_model (
    input wire logic clk_i,
    output logic ext_clk_o,
    output logic [5:0] ch_pin_o
);
    // pins idle low until commanded
    initial begin
        ext_clk_o = 1'b0;
        ch_pin_o = 6'h00;
    end
    // burst of external clock pulses, still low between bursts
    task automatic ext_burst(input int n);
        repeat (n) begin
            @(posedge clk_i) ext_clk_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            ext_clk_o <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask
    // channel pin levels
    task automatic ch_set(input logic [5:0] v);
        @(posedge clk_i) ch_pin_o <= v;
    endtask
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/10ps
module tb_top import tmcore_pkg::*;;
    logic clk, rst_b, psel, pen, pwr, ext, prdy, slv, lslv, force_in, ovf_irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r, r2;
    logic [5:0] ch_in, ch_out, ch_oe_b, ch_irq;
    int fails, compares, cyc, t0, n_ext, cnt;
    // reset view of the register map
    logic [7:0] ra[$] = {A_STAT, A_CNTH, A_CNTL, A_MODH, A_MODL, A_CSC};
    logic [31:0] rv[$] = {32'h20, 32'h0, 32'h0, 32'hFF, 32'hFF, 32'h0};
    tmcore_top i_dut (.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(prdy), .PSLVERR_O(slv),
        .EXT_CLK_PIN_I(ext), .EXT_PIN_FORCE_IN_O(force_in), .CH_PIN_I(ch_in), .CH_PIN_O(ch_out),
        .CH_PIN_OE_B_O(ch_oe_b), .OVF_IRQ_O(ovf_irq), .CH_IRQ_O(ch_irq));
    tmcore_pin_model i_pin (.clk_i(clk), .ext_clk_o(ext), .ch_pin_o(ch_in));
    // one bus transfer, held until ready is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) begin
            @(posedge clk);
        end
        r = prdata;
        lslv = slv;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic cmp_rng(input string s, input int lo, input int hi, input logic [31:0] g);
        compares++;
        if ($isunknown(g) || g < lo || g > hi) begin
            fails++;
            $display("mismatch %s expected %0d..%0d seen %h", s, lo, hi, g);
        end
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp($sformatf("reg %h", a), e, r);
    endtask
    task automatic close_out;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // cycle count and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end
    // main sequence
    initial begin
        {rst_b, psel, pen, pwr, paddr, pwdata} = '0;
        void'($urandom(32'h61d74bcb));
        n_ext = 5 + $urandom % 20;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        foreach (ra[i]) chk(ra[i], rv[i]);
        cmp("pin", 6'h3F, ch_out);
        bus(1'b1, 8'hFC, $urandom);
        cmp("slverr", 1'b1, lslv);
        bus(1'b1, A_STAT, 32'hA0);
        chk(A_STAT, 32'h20);
        for (int ps = 0; ps < 8; ps++) begin
            bus(1'b1, A_STAT, 32'h30 | ps);
            chk(A_CNTH, 32'h0);
            chk(A_CNTL, 32'h0);
            bus(1'b1, A_STAT, 32'h10 | ps);
            t0 = cyc;
            if (ps == 7)
                i_pin.ext_burst(n_ext);
            else
                repeat (400) @(posedge clk);
            bus(1'b1, A_STAT, 32'h20 | ps);
            t0 = (ps == 7) ? n_ext : (cyc - t0) >> ps;
            cmp("force_in", ps == 7, force_in);
            chk(A_STAT, 32'h20 | ps);
            bus(1'b0, A_CNTH, 32'h0);
            cnt = r[7:0] << 8;
            bus(1'b0, A_CNTL, 32'h0);
            cnt = cnt | r[7:0];
            cmp_rng("count", t0 - (ps < 7 ? 4 : 0), t0 + (ps < 7 ? 2 : 0), cnt);
        end
        bus(1'b1, A_STAT, 32'h16);
        bus(1'b0, A_CNTH, 32'h0);
        repeat (300) @(posedge clk);
        bus(1'b0, A_CNTH, 32'h0);
        bus(1'b0, A_CNTL, 32'h0);
        r2 = r;
        bus(1'b0, A_CNTL, 32'h0);
        cmp_rng("latch", 4, 6, r[7:0] - r2[7:0]);
        bus(1'b1, A_STAT, 32'h30);
        bus(1'b1, A_MODH, 32'h0);
        bus(1'b1, A_STAT, 32'h50);
        repeat (600) @(posedge clk);
        cmp("ovf_irq", 1'b0, ovf_irq);
        chk(A_STAT, 32'h40);
        bus(1'b1, A_MODL, 32'h2);
        bus(1'b1, A_STAT, 32'h50);
        repeat (10) @(posedge clk);
        cmp("ovf_irq", 1'b1, ovf_irq);
        chk(A_STAT, 32'hC0);
        bus(1'b1, A_STAT, 32'h40);
        chk(A_STAT, 32'hC0);
        bus(1'b1, A_STAT, 32'h56);
        repeat (250) @(posedge clk);
        chk(A_STAT, 32'hC6);
        bus(1'b1, A_STAT, 32'h46);
        repeat (3) @(posedge clk);
        cmp("ovf_irq", 1'b0, ovf_irq);
        chk(A_STAT, 32'h46);
        repeat (150) @(posedge clk);
        chk(A_STAT, 32'hC6);
        bus(1'b1, A_STAT, 32'hA6);
        chk(A_STAT, 32'hA6);
        bus(1'b1, A_STAT, 32'h66);
        chk(A_STAT, 32'hE6);
        bus(1'b1, A_STAT, 32'h30);
        bus(1'b1, A_MODH, 32'hFF);
        bus(1'b1, A_MODL, 32'hFF);
        bus(1'b1, A_CVAL, 32'h40);
        bus(1'b1, A_CSC, 32'h58);
        for (int c = 1; c < 4; c++)
            bus(1'b1, 8'(A_CSC + 4 * c), 32'h40 | c << 2);
        bus(1'b1, 8'(A_CSC + 8'h10), 32'h10);
        cmp("oe_b", 6'h3E, ch_oe_b);
        i_pin.ch_set(6'h0E);
        repeat (8) @(posedge clk);
        i_pin.ch_set(6'h00);
        repeat (8) @(posedge clk);
        cmp("ch_irq", 6'h00, ch_irq);
        cmp("pin", 6'h2F, ch_out);
        bus(1'b1, A_STAT, 32'h10);
        i_pin.ch_set(6'h0E);
        repeat (80) @(posedge clk);
        cmp("ch_irq", 6'h0B, ch_irq);
        cmp("pin", 6'h2E, ch_out);
        i_pin.ch_set(6'h00);
        repeat (8) @(posedge clk);
        cmp("ch_irq", 6'h0F, ch_irq);
        chk(A_CSC + 8'h04, 32'hC4);
        bus(1'b1, A_CSC + 8'h04, 32'h44);
        repeat (3) @(posedge clk);
        cmp("ch_irq", 6'h0D, ch_irq);
        bus(1'b1, A_CSC, 32'h78);
        chk(A_CSC + 8'h04, 32'h0);
        close_out();
    end
endmodule
bind tmcore_top tmcore_checker i_chk (.CLK_I, .RST_B_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PRDATA_O,
    .PREADY_O, .PSLVERR_O, .EXT_PIN_FORCE_IN_O, .OVF_IRQ_O, .CH_IRQ_O);
